/* File: core/boost_idle_ctrl.sv */
// Boost control, feedback counters, feature query and per-processor idle entry.
// Assumes one register access or query per cycle from the pipeline, single clock.
`include "boost_idle_params.svh"
`timescale 1ns/1ps
`default_nettype none
module boost_idle_ctrl
   import boost_idle_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic                    boost_supported,
   input  wire logic                    reg_valid,
   input  wire logic                    reg_write,
   input  wire logic [`LP_W-1:0]        reg_lp,
   input  wire logic [31:0]             reg_addr,
   input  wire logic [63:0]             reg_wdata,
   output logic      [63:0]             reg_rdata,
   output logic                         reg_ack,
   output logic                         reg_fault,
   input  wire logic                    query_valid,
   input  wire logic [31:0]             query_leaf,
   output logic      [31:0]             query_eax,
   output logic      [31:0]             query_ecx,
   output logic      [31:0]             query_edx,
   output logic                         query_ack,
   input  wire logic [`NUM_LP-1:0]      perf_request,
   input  wire logic                    headroom_pin,
   input  wire logic                    criteria_met,
   output logic                         boost_active,
   output logic      [`LP_W-1:0]        boost_lp,
   input  wire logic [`NUM_LP-1:0]      wait_req,
   input  wire logic [`NUM_LP*8-1:0]    wait_hint,
   input  wire logic [`NUM_LP*8-1:0]    wait_ext,
   input  wire logic [`NUM_LP*2-1:0]    wait_priv,
   input  wire logic                    user_wait_ok,
   input  wire logic [`NUM_LP-1:0]      irq_pending,
   input  wire logic [`NUM_LP-1:0]      irq_enabled,
   input  wire logic [`NUM_LP-1:0]      store_hit,
   input  wire logic [`NUM_LP-1:0]      store_from_cpu,
   output logic      [`NUM_LP-1:0]      wait_fault,
   output logic      [`NUM_LP-1:0]      wait_done,
   output logic      [`NUM_LP*4-1:0]    idle_state
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic                  boost_dis_r;
   logic [15:0]           target_r [`NUM_LP];
   logic                  diseng_r [`NUM_LP];
   logic [63:0]           ref_cnt_r [`NUM_LP];
   logic [63:0]           act_cnt_r [`NUM_LP];
   logic [2:0]            hr_sync_r;
   logic                  headroom_r;
   logic [7:0]            ref_div_r;
   logic [7:0]            trans_r;
   boost_st_t             bst_r, bst_nxt;
   logic [`LP_W-1:0]      blp_r, blp_nxt;
   logic [63:0]           rdata_r;
   logic                  ack_r;
   logic                  fault_r;
   logic [31:0]           q_eax_r, q_ecx_r, q_edx_r;
   logic                  q_ack_r;
   logic [`NUM_LP-1:0]    in_run;

   // Address match helper, used by read and write decode
   function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
      hit = (a == ref_a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Headroom pin: three flops, change taken once second and third agree
   always_ff @(posedge clk) begin
      if (!reset_n)
         hr_sync_r <= 3'h0;
      else
         hr_sync_r <= {hr_sync_r[1:0], headroom_pin};
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         headroom_r <= 1'b0;
      else if (hr_sync_r[1] == hr_sync_r[2])
         headroom_r <= hr_sync_r[2];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire   wr        = reg_valid && reg_write;
   wire   a_feat    = hit(reg_addr, `FEAT_EN_ADDR);
   wire   a_stat    = hit(reg_addr, `PERF_STATUS_ADDR);
   wire   a_ctl     = hit(reg_addr, `PERF_CTL_ADDR);
   wire   a_ref     = hit(reg_addr, `REF_CNT_ADDR);
   wire   a_act     = hit(reg_addr, `ACT_CNT_ADDR);
   wire   a_any     = a_feat || a_stat || a_ctl || a_ref || a_act;
   // Status is read-only; a write to it faults like an unmapped address
   wire   bad_acc   = !a_any || (a_stat && reg_write);
   wire   boost_en  = !boost_dis_r;
   wire   ref_tick  = (ref_div_r == 8'h00);
   wire   trans_done = (trans_r == 8'h00);

   // Read mux; reserved bits read as zero
   logic [63:0] rd_mux;
   always_comb begin
      rd_mux = 64'h0;
      if (a_feat)
         rd_mux[`BOOST_DIS_BIT] = boost_dis_r;
      else if (a_ctl) begin
         rd_mux[15:0] = target_r[reg_lp];
         rd_mux[`DISENGAGE_BIT] = diseng_r[reg_lp];
      end else if (a_stat)
         // RULE6: disengage not mirrored in status
         rd_mux[15:0] = (boost_active && boost_lp == reg_lp) ? `BOOST_POINT
                                                              : target_r[reg_lp];
      else if (a_ref)
         rd_mux = ref_cnt_r[reg_lp];
      else if (a_act)
         rd_mux = act_cnt_r[reg_lp];
   end

   // Access answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_r <= 64'h0;
         ack_r <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         ack_r <= reg_valid;
         fault_r <= reg_valid && bad_acc;
         if (reg_valid && !reg_write && !bad_acc)
            rdata_r <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Package-wide boost-disable bit
   always_ff @(posedge clk) begin
      if (!reset_n)
         // RULE1: power-on value from support strap
         boost_dis_r <= boost_supported;
      else if (wr && a_feat)
         // RULE2: single copy shared by all processors
         // RULE3: one disables, zero enables
         boost_dis_r <= reg_wdata[`BOOST_DIS_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-processor control registers and feedback counters
   always_ff @(posedge clk) begin
      if (!reset_n)
         ref_div_r <= 8'h00;
      else if (ref_tick)
         ref_div_r <= 8'(`REF_DIV_CYC - 1);
      else
         ref_div_r <= ref_div_r - 8'h01;
   end

   genvar g;
   generate
      for (g = 0; g < `NUM_LP; g++) begin : lp_g
         wire          me       = (reg_lp == `LP_W'(g));
         wire          boosted  = boost_active && (boost_lp == `LP_W'(g));
         // RULE9: boosted processor counts faster than reference
         wire   [63:0] act_step = boosted ? `ACT_STEP_BOOST : `ACT_STEP_NORM;
         wire          count_on = ref_tick && in_run[g];
         wire          ref_ovf  = count_on && (ref_cnt_r[g] == 64'hFFFF_FFFF_FFFF_FFFF);
         wire          act_ovf  = count_on && (act_cnt_r[g] > ~act_step);

         // RULE5: per-processor disengage bit, software preserves others
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               target_r[g] <= 16'h0000;
               diseng_r[g] <= 1'b0;
            end else if (wr && a_ctl && me) begin
               target_r[g] <= reg_wdata[15:0];
               diseng_r[g] <= reg_wdata[`DISENGAGE_BIT];
            end
         end

         // Counters run only while the processor is not idle
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               ref_cnt_r[g] <= 64'h0;
               act_cnt_r[g] <= 64'h0;
            end else if (ref_ovf || act_ovf) begin
               // RULE19: either overflow clears both
               ref_cnt_r[g] <= 64'h0;
               act_cnt_r[g] <= 64'h0;
            end else begin
               if (wr && a_ref && me)
                  ref_cnt_r[g] <= reg_wdata;
               else if (count_on)
                  ref_cnt_r[g] <= ref_cnt_r[g] + 64'h1;
               if (wr && a_act && me)
                  act_cnt_r[g] <= reg_wdata;
               else if (count_on)
                  act_cnt_r[g] <= act_cnt_r[g] + act_step;
            end
         end

         // Idle-state unit for this processor
         idle_req_if link ();
         assign link.wait_req       = wait_req[g];
         assign link.hint           = wait_hint[g*8 +: 8];
         assign link.ext            = wait_ext[g*8 +: 8];
         assign link.priv           = wait_priv[g*2 +: 2];
         assign link.user_wait_ok   = user_wait_ok;
         assign link.irq_pending    = irq_pending[g];
         assign link.irq_enabled    = irq_enabled[g];
         assign link.store_hit      = store_hit[g];
         assign link.store_from_cpu = store_from_cpu[g];
         assign wait_fault[g]       = link.fault;
         assign wait_done[g]        = link.wake_done;
         assign in_run[g]           = link.in_run;
         assign idle_state[g*4 +: 4] = link.cur_state;

         idle_entry u_idle (
            .clk     (clk),
            .reset_n (reset_n),
            .bus     (link.unit)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Boost candidate: lowest-numbered running, engaged, requesting processor
   logic             cand_ok;
   logic [`LP_W-1:0] cand_lp;
   always_comb begin
      cand_ok = 1'b0;
      cand_lp = '0;
      for (int i = `NUM_LP - 1; i >= 0; i--) begin
         if (perf_request[i] && !diseng_r[i] && in_run[i]) begin
            cand_ok = 1'b1;
            cand_lp = `LP_W'(i);
         end
      end
   end

   // RULE7: entry needs enable, headroom and criteria
   wire go_ok   = boost_en && headroom_r && criteria_met;
   // Boosted processor must keep asking, stay engaged and awake
   wire keep_ok = go_ok && perf_request[blp_r] && !diseng_r[blp_r] && in_run[blp_r];

   // Boost sequencer
   always_comb begin
      bst_nxt = bst_r;
      blp_nxt = blp_r;
      case (bst_r)
         BOOST_OFF:
            // RULE8: one core at a time
            if (go_ok && cand_ok) begin
               bst_nxt = BOOST_ENTER;
               blp_nxt = cand_lp;
            end
         BOOST_ENTER:
            if (!keep_ok)
               bst_nxt = BOOST_EXIT;
            else if (trans_done)
               bst_nxt = BOOST_ON;
         BOOST_ON:
            if (!keep_ok)
               bst_nxt = BOOST_EXIT;
         BOOST_EXIT:
            // RULE20: finish leaving before any new entry
            if (trans_done)
               bst_nxt = BOOST_OFF;
         default:
            bst_nxt = BOOST_OFF;
      endcase
   end

   // Sequencer state and operating-point transition timer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bst_r <= BOOST_OFF;
         blp_r <= '0;
         trans_r <= 8'h00;
      end else begin
         bst_r <= bst_nxt;
         blp_r <= blp_nxt;
         if (bst_nxt != bst_r && (bst_nxt == BOOST_ENTER || bst_nxt == BOOST_EXIT))
            trans_r <= 8'(`BOOST_TRANS_CYC - 1);
         else if (!trans_done)
            trans_r <= trans_r - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Feature query answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q_eax_r <= 32'h0;
         q_ecx_r <= 32'h0;
         q_edx_r <= 32'h0;
         q_ack_r <= 1'b0;
      end else begin
         q_ack_r <= query_valid;
         if (query_valid) begin
            q_eax_r <= 32'h0;
            q_ecx_r <= 32'h0;
            q_edx_r <= 32'h0;
            if (query_leaf == `LEAF_PWR) begin
               // RULE4: enabled status, zero when disabled
               q_eax_r[`PWR_BOOST_BIT] <= boost_en;
               q_ecx_r[`PWR_FEEDBACK_BIT] <= 1'b1;
            end else if (query_leaf == `LEAF_WAIT) begin
               // RULE10: extensions supported
               q_ecx_r[`WAIT_EXT_BIT] <= 1'b1;
               // RULE11: masked interrupt break supported
               q_ecx_r[`WAIT_IRQ_BRK_BIT] <= 1'b1;
               // RULE13: sub-state count per state, states 1 to max
               for (int s = 1; s <= 7; s++) begin
                  if (4'(s) <= `MAX_CSTATE)
                     q_edx_r[s*4 +: 4] <= `SUBSTATES;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata    = rdata_r;
   assign reg_ack      = ack_r;
   assign reg_fault    = fault_r;
   assign query_eax    = q_eax_r;
   assign query_ecx    = q_ecx_r;
   assign query_edx    = q_edx_r;
   assign query_ack    = q_ack_r;
   // Boosted point only counts once the entry transition is over
   assign boost_active = (bst_r == BOOST_ON);
   assign boost_lp     = blp_r;
endmodule
`default_nettype wire

/* File: core/boost_idle_params.svh */
// Constants for the boost and idle-state control block: addresses, bits, timing.
// Assumes a 100 MHz core clock; included by both design modules, the checker and the bench.
// Operation
// RULE1: Disable bit powers up to the support strap.
// RULE2: One disable bit shared package-wide.
// RULE3: One disables boost, zero enables.
// RULE4: Leaf 06H accumulator bit 1 is boost enabled.
// RULE5: Control bit 32 disengages boost; read-modify-write.
// RULE6: Disengage is per processor, not in status.
// RULE7: Entry needs enable, headroom, criteria.
// RULE8: One core boosts on request.
// RULE9: Boosted counter ratio exceeds one.
// RULE10: Leaf 05H count bit 0: extensions.
// RULE11: Leaf 05H count bit 1: masked breaks.
// RULE12: Extension bit 0 lets masked interrupt wake.
// RULE13: Leaf 05H data lists idle states.
// RULE14: Privilege 0 never deeper than hint.
// RULE15: Above privilege 0 shallowest state only.
// RULE16: Disallowed wait raises exception.
// RULE17: Processor stores to armed range wake.
// RULE18: Deeper states have longer latency.
// RULE19: Either counter overflow clears both.
// RULE20: Disengage exits boost before new entry.
`ifndef BOOST_IDLE_PARAMS_SVH
`define BOOST_IDLE_PARAMS_SVH

`define NUM_LP            2
`define LP_W              1
`define FEAT_EN_ADDR      32'h0000_0300
`define PERF_STATUS_ADDR  32'h0000_0198
`define PERF_CTL_ADDR     32'h0000_0199
`define REF_CNT_ADDR      32'h0000_00E7
`define ACT_CNT_ADDR      32'h0000_00E8
`define BOOST_DIS_BIT     38
`define DISENGAGE_BIT     32
`define OP_POINT_W        16
`define BOOST_POINT       16'h00FF
`define LEAF_WAIT         32'h0000_0005
`define LEAF_PWR          32'h0000_0006
`define PWR_BOOST_BIT     1
`define PWR_FEEDBACK_BIT  0
`define WAIT_EXT_BIT      0
`define WAIT_IRQ_BRK_BIT  1
`define EXT_IRQ_BREAK_BIT 0
`define MAX_CSTATE        4'h3
`define SUBSTATES         4'h2
`define CLK_MHZ           100
`define REF_PERIOD_NS     40
`define REF_DIV_CYC       ((`REF_PERIOD_NS * `CLK_MHZ) / 1000)
`define BOOST_TRANS_NS    200
`define BOOST_TRANS_CYC   ((`BOOST_TRANS_NS * `CLK_MHZ) / 1000)
`define LAT_STEP_NS       80
`define LAT_STEP_CYC      ((`LAT_STEP_NS * `CLK_MHZ) / 1000)
`define ACT_STEP_NORM     64'h0000_0000_0000_0001
`define ACT_STEP_BOOST    64'h0000_0000_0000_0002

`endif

/* File: core/boost_idle_pkg.sv */
// Types shared by the boost and idle-state control modules.
// Assumes the constants header sits beside it.
package boost_idle_pkg;
   typedef enum logic [1:0] {BOOST_OFF, BOOST_ENTER, BOOST_ON, BOOST_EXIT} boost_st_t;
   typedef enum logic [1:0] {IDLE_RUN, IDLE_ENTER, IDLE_SLEEP, IDLE_EXIT} idle_st_t;
   typedef logic [3:0] cstate_t;
endpackage

/* File: core/idle_req_if.sv */
// Carrier between the top controller and one per-processor idle-entry unit.
// Assumes one clock; all signals are synchronous to it.
`timescale 1ns/1ps
`default_nettype none
interface idle_req_if;
   import boost_idle_pkg::*;
   logic       wait_req;
   logic [7:0] hint;
   logic [7:0] ext;
   logic [1:0] priv;
   logic       user_wait_ok;
   logic       irq_pending;
   logic       irq_enabled;
   logic       store_hit;
   logic       store_from_cpu;
   logic       fault;
   logic       in_run;
   logic       wake_done;
   cstate_t    cur_state;
   modport ctl  (output wait_req, hint, ext, priv, user_wait_ok, irq_pending, irq_enabled,
                 store_hit, store_from_cpu, input fault, in_run, wake_done, cur_state);
   modport unit (input wait_req, hint, ext, priv, user_wait_ok, irq_pending, irq_enabled,
                 store_hit, store_from_cpu, output fault, in_run, wake_done, cur_state);
endinterface
`default_nettype wire

/* File: core/idle_entry.sv */
// Idle-state entry and wake for one logical processor.
// Assumes the wait request is a one-cycle pulse, given only while in_run is high.
`include "boost_idle_params.svh"
`timescale 1ns/1ps
`default_nettype none
module idle_entry
   import boost_idle_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   idle_req_if.unit  bus
);
   idle_st_t   st_r, st_nxt;
   cstate_t    cs_r;
   logic [7:0] lat_r;
   logic       fault_r;
   logic       done_r;

   ////////////////////////////////////////////////////////////////////////////
   // Target state decode
   wire        priv0     = (bus.priv == 2'h0);
   // RULE16: privilege check fault
   wire        bad_priv  = !priv0 && !bus.user_wait_ok;
   wire [3:0]  hint_cs   = bus.hint[7:4] + 4'h1;
   // RULE14: clamp to hint
   wire [3:0]  cap_cs    = (hint_cs > `MAX_CSTATE) ? `MAX_CSTATE : hint_cs;
   // RULE15: user level shallowest only
   wire [3:0]  tgt_cs    = priv0 ? cap_cs : 4'h1;
   // RULE18: latency grows with depth
   wire [7:0]  tgt_lat   = 8'({4'h0, tgt_cs} * 8'(`LAT_STEP_CYC));
   // RULE12: masked interrupt still wakes when extension bit set
   wire        irq_wake  = bus.irq_pending && (bus.irq_enabled || bus.ext[`EXT_IRQ_BREAK_BIT]);
   // RULE17: processor stores wake; other agents ignored
   wire        store_wake = bus.store_hit && bus.store_from_cpu;
   wire        wake      = irq_wake || store_wake;
   wire        accept    = (st_r == IDLE_RUN) && bus.wait_req && !bad_priv;
   wire        lat_zero  = (lat_r == 8'h00);

   // Sequencer; a wake during entry aborts straight into the exit phase
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         IDLE_RUN:   if (accept) st_nxt = IDLE_ENTER;
         IDLE_ENTER: if (wake) st_nxt = IDLE_EXIT;
                     else if (lat_zero) st_nxt = IDLE_SLEEP;
         IDLE_SLEEP: if (wake) st_nxt = IDLE_EXIT;
         IDLE_EXIT:  if (lat_zero) st_nxt = IDLE_RUN;
         default:    st_nxt = IDLE_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State, depth and latency counter
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= IDLE_RUN;
         cs_r <= 4'h0;
         lat_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         if (accept) begin
            cs_r <= tgt_cs;
            lat_r <= tgt_lat;
         end else if (st_r != st_nxt && st_nxt == IDLE_EXIT) begin
            lat_r <= 8'({4'h0, cs_r} * 8'(`LAT_STEP_CYC));
         end else if (!lat_zero) begin
            lat_r <= lat_r - 8'h01;
         end
         if (st_nxt == IDLE_RUN)
            cs_r <= 4'h0;
      end
   end

   // Pulses for fault and completed wake
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fault_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         fault_r <= (st_r == IDLE_RUN) && bus.wait_req && bad_priv;
         done_r <= (st_r == IDLE_EXIT) && lat_zero;
      end
   end

   assign bus.fault     = fault_r;
   assign bus.wake_done = done_r;
   assign bus.in_run    = (st_r == IDLE_RUN);
   assign bus.cur_state = cs_r;
endmodule
`default_nettype wire

/* File: bench/boost_idle_properties.sv */
// Checker on the boost and idle controller ports, lp0 idle side only.
// Assumes a bind onto boost_idle_ctrl, ports matched by name.
`include "boost_idle_params.svh"
`timescale 1ns/1ps
`default_nettype none
module boost_idle_properties
   import boost_idle_pkg::*;
(
   input wire logic        clk, reset_n, boost_supported, reg_valid, reg_write,
   input wire logic        query_valid, boost_active, user_wait_ok,
   input wire logic [31:0] reg_addr, query_leaf, query_eax, query_ecx,
   input wire logic [63:0] reg_wdata,
   input wire logic [1:0]  wait_req, wait_fault,
   input wire logic [3:0]  wait_priv,
   input wire logic [15:0] wait_hint,
   input wire logic [7:0]  idle_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic dis_r;
   // Shadow of the shared disable bit; strap value while in reset
   always_ff @(posedge clk) begin
      if (!reset_n)
         dis_r <= boost_supported;
      else if (reg_valid && reg_write && reg_addr == `FEAT_EN_ADDR)
         dis_r <= reg_wdata[`BOOST_DIS_BIT];
   end
   sequence s_run_wait;
      wait_req[0] && wait_priv[1:0] == 2'h0;
   endsequence
   sequence s_user_ok;
      wait_req[0] && wait_priv[1:0] != 2'h0 && user_wait_ok;
   endsequence
   sequence s_user_bad;
      wait_req[0] && wait_priv[1:0] != 2'h0 && !user_wait_ok;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   enable_report_a: assert property (query_valid && query_leaf == `LEAF_PWR |=>
      query_eax[1] == !$past(dis_r)) else $error("boost status bit wrong");
   wait_caps_a: assert property (query_valid && query_leaf == `LEAF_WAIT |=>
      query_ecx[0]) else $error("wait extension bit missing");
   break_cap_a: assert property (query_valid && query_leaf == `LEAF_WAIT |=>
      query_ecx[1]) else $error("break event bit missing");
   boost_gate_a: assert property ($rose(boost_active) |-> !dis_r)
      else $error("boost entered while disabled");
   exit_hold_a: assert property ($fell(boost_active) |-> !boost_active [*8])
      else $error("boost re-entered during exit");
   hint_limit_a: assert property (s_run_wait |=> idle_state[3:0] != 4'h0 &&
      {1'b0, idle_state[3:0]} <= {1'b0, $past(wait_hint[7:4])} + 5'h01)
      else $error("idle deeper than hint");
   shallow_only_a: assert property (s_user_ok |=> idle_state[3:0] == 4'h1)
      else $error("user wait not shallowest");
   priv_fault_a: assert property (s_user_bad |=> wait_fault[0])
      else $error("no fault for user wait");
endmodule
`default_nettype wire

/* File: bench/store_agent.sv */
// Model of a store by the processor or by another agent to the armed range of lp0.
// Assumes one clock; fire is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module store_agent (
   input  wire logic       clk,
   input  wire logic       fire,
   input  wire logic       from_cpu,
   input  wire logic [3:0] delay,
   output logic            store_hit,
   output logic            store_from_cpu
);
   logic [4:0] cnt_r = 5'h00;
   logic       cpu_r = 1'b0;
   // store lands after a variable delay, for two cycles
   always_ff @(posedge clk) begin
      if (fire) cnt_r <= {1'b0, delay} + 5'h02;
      else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
      if (fire) cpu_r <= from_cpu;
   end
   // Source flag is the inverse of the latched flag outside the store, never a stale copy
   assign store_hit      = (cnt_r == 5'h01) || (cnt_r == 5'h02);
   assign store_from_cpu = store_hit ? cpu_r : !cpu_r;
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench: registers, queries, boost entry and idle entry of lp0.
// Assumes checker and store agent compile first.
`include "boost_idle_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   import boost_idle_pkg::*;
   logic        clk = '0, reset_n = '0, boost_supported = '1, reg_valid = '0, reg_write = '0;
   logic        reg_lp = '0, query_valid = '0, headroom_pin = '0, criteria_met = '0;
   logic        user_wait_ok = '0, fire = '0, fcpu = '0, sh, sfc, reg_ack, reg_fault;
   logic        query_ack, boost_active, boost_lp;
   logic [31:0] reg_addr = '0, query_leaf = '0, query_eax, query_ecx, query_edx;
   logic [63:0] reg_wdata = '0, reg_rdata, last_rd, rref;
   logic [1:0]  perf_request = '0, wait_req = '0, irq_pending = '0, irq_enabled = '0;
   logic [1:0]  store_hit, store_from_cpu, wait_fault, wait_done;
   logic [15:0] wait_hint = '0, wait_ext = '0, tgt;
   logic [3:0]  wait_priv = '0;
   logic [7:0]  idle_state;
   logic [65:0] re, rq[$];
   logic [95:0] qq[$];
   int          failures = 0, check_count = 0, i, seed = 32'h8E19E5B2;
   assign store_hit      = {1'b0, sh};
   assign store_from_cpu = {1'b0, sfc};
   initial forever #5 clk = ~clk;
   boost_idle_ctrl u_dut (.*);
   store_agent u_agent (.clk(clk), .fire(fire), .from_cpu(fcpu), .delay(tgt[3:0]),
      .store_hit(sh), .store_from_cpu(sfc));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [95:0] got, exp, input string m);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Counter read data is not compared
   task automatic reg_op(input logic w, lp, input logic [31:0] a, input logic [63:0] d, f);
      @(posedge clk);
      reg_valid <= 1'b1; reg_write <= w; reg_lp <= lp; reg_addr <= a; reg_wdata <= d;
      rq.push_back({!w && !f && a[31:4] != 28'h000000E, f, d});
      @(posedge clk);
      reg_valid <= 1'b0;
   endtask
   task automatic q_op(input logic [31:0] leaf, input logic [95:0] e);
      @(posedge clk);
      query_valid <= 1'b1; query_leaf <= leaf;
      qq.push_back(e);
      @(posedge clk);
      query_valid <= 1'b0;
   endtask
   task automatic wait_ack;
      for (i = 0; i < 150 && wait_done[0] !== 1'b1; i++) @(negedge clk);
   endtask
   // Wait on lp0, then wake by interrupt or store; recover with an enabled interrupt
   task automatic idle_run(input logic [7:0] h, input logic x, ir, st, cpu, ok);
      @(posedge clk);
      wait_hint <= {8'h00, h}; wait_ext <= {15'h0000, x}; wait_req <= 2'b01;
      @(posedge clk);
      wait_req <= 2'b00; irq_pending <= {1'b0, ir}; fire <= st; fcpu <= cpu;
      @(posedge clk);
      fire <= 1'b0;
      wait_ack();
      chk(wait_done[0], ok, "wake");
      @(posedge clk);
      irq_pending <= {1'b0, !ok}; irq_enabled <= {1'b0, !ok};
      if (!ok) wait_ack();
      @(posedge clk);
      irq_pending <= 2'b00; irq_enabled <= 2'b00;
   endtask
   // Results are compared in arrival order as the acknowledges come back
   always @(negedge clk) begin
      if (reg_ack === 1'b1) begin
         re = rq.pop_front();
         last_rd = reg_rdata;
         chk(reg_fault, re[64], "fault");
         if (re[65]) chk(reg_rdata, re[63:0], "rdata");
      end
      if (query_ack === 1'b1) chk({query_eax, query_ecx, query_edx}, qq.pop_front(), "query");
   end
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end
   initial begin
      tgt = $random(seed);
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      reg_op(0, 0, `FEAT_EN_ADDR, 64'h0000_0040_0000_0000, 0);
      q_op(`LEAF_PWR, {32'h0, 32'h1, 32'h0});
      q_op(`LEAF_WAIT, {32'h0, 32'h3, 32'h2220});
      q_op(32'h7, 96'h0);
      $display("caps test done");
      reg_op(1, 0, `FEAT_EN_ADDR, 64'h0, 0);
      reg_op(0, 1, `FEAT_EN_ADDR, 64'h0, 0);
      q_op(`LEAF_PWR, {32'h2, 32'h1, 32'h0});
      reg_op(1, 0, `PERF_CTL_ADDR, {31'h0, 1'b1, 16'h0, tgt}, 0);
      reg_op(0, 0, `PERF_CTL_ADDR, {31'h0, 1'b1, 16'h0, tgt}, 0);
      reg_op(0, 1, `PERF_CTL_ADDR, 64'h0, 0);
      reg_op(0, 0, `PERF_STATUS_ADDR, {48'h0, tgt}, 0);
      reg_op(1, 0, `PERF_STATUS_ADDR, 64'h0, 1);
      reg_op(0, 0, 32'h0000_0123, 64'h0, 1);
      $display("register test done");
      perf_request <= 2'b01; headroom_pin <= 1'b1; criteria_met <= 1'b1;
      reg_op(1, 0, `PERF_CTL_ADDR, {48'h0, tgt}, 0);
      for (i = 0; i < 200 && boost_active !== 1'b1; i++) @(negedge clk);
      chk({boost_active, boost_lp}, 2'b10, "boost");
      reg_op(0, 0, `PERF_STATUS_ADDR, {48'h0, `BOOST_POINT}, 0);
      reg_op(1, 0, `REF_CNT_ADDR, 64'h0, 0);
      reg_op(1, 0, `ACT_CNT_ADDR, 64'h0, 0);
      repeat (40) @(posedge clk);
      reg_op(0, 0, `REF_CNT_ADDR, 64'h0, 0);
      @(negedge clk) rref = reg_rdata;
      reg_op(0, 0, `ACT_CNT_ADDR, 64'h0, 0);
      @(negedge clk) chk(reg_rdata > rref, 1'b1, "ratio");
      reg_op(1, 0, `PERF_CTL_ADDR, {31'h0, 1'b1, 16'h0, tgt}, 0);
      repeat (30) @(negedge clk);
      chk(boost_active, 1'b0, "exit");
      @(posedge clk) perf_request <= 2'b00;
      $display("boost test done");
      idle_run(8'h10, 0, 1, 0, 0, 0);
      idle_run(8'h10, 1, 1, 0, 0, 1);
      idle_run(8'h20, 0, 0, 1, 0, 0);
      idle_run(8'h00, 0, 0, 1, 1, 1);
      @(posedge clk) wait_priv <= 4'h3; wait_req <= 2'b01;
      @(posedge clk) wait_req <= 2'b00;
      @(negedge clk) chk(wait_fault[0], 1'b1, "fault");
      @(posedge clk) user_wait_ok <= 1'b1;
      idle_run(8'h20, 1, 1, 0, 0, 1);
      $display("idle test done");
      tally_and_finish();
   end
endmodule
bind boost_idle_ctrl boost_idle_properties u_props (.*);
`default_nettype wire
